// ### logic/pcm_pin_cell.sv
// One upper pin's function selection: segment, peripheral or port
`timescale 1ns/10ps
`default_nettype none
module pcm_pin_cell
	import pcm_pkg::*;
(
	input wire logic seg_en,
	input wire logic dir_in,
	input wire logic latch_bit,
	input wire logic periph_oe,
	input wire logic periph_out,
	input wire logic open_drain,
	output logic pad_out,
	output logic pad_oe
);

	// Segment wins over everything; a driving peripheral ignores direction
	always_comb
	begin
		pad_out = 1'b0;
		pad_oe = 1'b0;
		if (seg_en)
		begin
			pad_out = 1'b0;
			pad_oe = 1'b0;
		end
		else if (periph_oe)
		begin
			// Open drain only pulls low, floats for a one
			pad_out = open_drain ? 1'b0 : periph_out;
			pad_oe = open_drain ? ~periph_out : 1'b1;
		end
		else
		begin
			pad_out = latch_bit;
			pad_oe = ~dir_in;
		end
	end

endmodule : pcm_pin_cell
`default_nettype wire

// ### logic/pcm_pkg.sv
// Package with register map, field positions and pin signal carriers for the port C upper mux
package pcm_pkg;

	// Register byte addresses (one aligned word each)
	localparam logic [7:0] PCM_ADDR_PIN_LEVELS = 8'h00;
	localparam logic [7:0] PCM_ADDR_LATCH = 8'h04;
	localparam logic [7:0] PCM_ADDR_DIRECTION = 8'h08;
	localparam logic [7:0] PCM_ADDR_SEG_8_15 = 8'h0c;
	localparam logic [7:0] PCM_ADDR_SEG_16_23 = 8'h10;
	localparam logic [7:0] PCM_ADDR_SEG_24_31 = 8'h14;
	localparam logic [7:0] PCM_ADDR_SEG_32_39 = 8'h18;
	localparam logic [7:0] PCM_ADDR_OPEN_DRAIN = 8'h1c;

	// Reset values: pins come up as inputs, segments off, push-pull
	localparam logic [7:0] PCM_RST_LATCH = 8'h00;
	localparam logic [7:0] PCM_RST_DIRECTION = 8'hff;
	localparam logic [7:0] PCM_RST_SEG = 8'h00;
	localparam logic [7:0] PCM_RST_OPEN_DRAIN = 8'h00;

	// Field positions
	localparam int PCM_SEG_EN_27_BIT = 3;
	localparam int PCM_SEG_EN_28_BIT = 4;
	localparam int PCM_PIN6 = 6;
	localparam int PCM_PIN7 = 7;
	localparam int PCM_OD_SERIAL2_BIT = 0;
	localparam int PCM_OD_COMPARE1_BIT = 5;
	localparam int PCM_OD_COMPARE2_BIT = 6;
	localparam int PCM_OD_SERIAL1_BIT = 7;

	// Writable masks
	localparam logic [7:0] PCM_OD_MASK = 8'he1;
	localparam logic [7:0] PCM_SEG4_SMALL_MASK = 8'h01;

	// AHB constants
	localparam logic [1:0] PCM_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] PCM_HTRANS_SEQ = 2'h3;

	// Upper pin signals toward the package pads
	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
		logic [1:0] seg_sel;
	} pcm_pad_s;

	// Serial transceiver signals touching pins 6 and 7
	typedef struct packed {
		logic tx_out;
		logic tx_oe;
		logic sync_data_out;
		logic sync_data_oe;
	} pcm_serial_s;

endpackage : pcm_pkg

// ### logic/pcm_port_mux.sv
// Port C upper pin function mux with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module pcm_port_mux
	import pcm_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] pad_in,
	input wire pcm_serial_s serial_in,
	output pcm_pad_s pad_q,
	output logic async_receive_in,
	output logic sync_serial_line_in,
	output logic [1:0] serial_port_open_drain,
	output logic [1:0] compare_unit_open_drain
);

	// Software-visible registers
	logic [7:0] latch_q;
	logic [7:0] dir_q;
	logic [7:0] seg1_q;
	logic [7:0] seg2_q;
	logic [7:0] seg3_q;
	logic [7:0] seg4_q;
	logic [7:0] od_q;

	// Bus pipeline state
	logic wr_pend_q;
	logic [7:0] wr_addr_q;

	// Cell wiring and read path
	logic [7:0] seg4_mask;
	logic [1:0] cell_out;
	logic [1:0] cell_oe;
	logic [1:0] cell_seg;
	logic [1:0] cell_periph_oe;
	logic [1:0] cell_periph_out;
	logic [1:0] cell_od;
	logic rd_take;
	logic wr_take;
	logic [7:0] rd_byte;

	// Forwarding and receive gating
	logic [7:0] fwd_byte;
	logic [7:0] pin_view;
	logic rx_async_open;
	logic rx_sync_open;

	// Byte address decode shared by read and write paths
	function automatic logic [7:0] word_addr(input logic [31:0] a);
		word_addr = {a[7:2], 2'b00};
	endfunction : word_addr

	// Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored
	function automatic logic xfer_valid(input logic [1:0] t);
		xfer_valid = (t == PCM_HTRANS_NONSEQ) || (t == PCM_HTRANS_SEQ);
	endfunction : xfer_valid

	// Value a register holds after a write, unimplemented bits dropped;
	// shared by the store and the forward so the two cannot disagree
	function automatic logic [7:0] write_view(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] m4);
		case (a)
			PCM_ADDR_SEG_32_39: write_view = d & m4;
			PCM_ADDR_OPEN_DRAIN: write_view = d & PCM_OD_MASK;
			default: write_view = d;
		endcase
	endfunction : write_view

	assign seg4_mask = SMALL_PACKAGE ? PCM_SEG4_SMALL_MASK : 8'hff;
	assign rd_take = hsel && hready && !hwrite && xfer_valid(htrans);
	assign wr_take = hsel && hready && hwrite && xfer_valid(htrans);

	// Zero wait states, always OKAY; unmapped reads return zero
	// The slave never stretches a transfer, so hreadyout is a constant flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Register the write address phase; data arrives next cycle
	// hwdata is only valid in the data phase, one cycle after the address
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= wr_take;
			if (wr_take)
			begin
				wr_addr_q <= word_addr(haddr);
			end
		end
	end

	// Read mux; pin levels come from pads, latch from its register
	always_comb
	begin
		rd_byte = 8'h00;
		case (word_addr(haddr))
			PCM_ADDR_PIN_LEVELS: rd_byte = pin_view;
			PCM_ADDR_LATCH: rd_byte = latch_q;
			PCM_ADDR_DIRECTION: rd_byte = dir_q;
			PCM_ADDR_SEG_8_15: rd_byte = seg1_q;
			PCM_ADDR_SEG_16_23: rd_byte = seg2_q;
			PCM_ADDR_SEG_24_31: rd_byte = seg3_q;
			PCM_ADDR_SEG_32_39: rd_byte = seg4_q & seg4_mask;
			PCM_ADDR_OPEN_DRAIN: rd_byte = od_q & PCM_OD_MASK;
			default: rd_byte = 8'h00;
		endcase
	end

	// A pipelined master may place a read address phase in the data phase of a
	// write; the register only updates at the end of that phase, so forward it
	always_comb
	begin
		fwd_byte = rd_byte;
		if (wr_pend_q && (wr_addr_q == word_addr(haddr))
			&& (wr_addr_q != PCM_ADDR_PIN_LEVELS) && (wr_addr_q <= PCM_ADDR_OPEN_DRAIN))
		begin
			fwd_byte = write_view(wr_addr_q, hwdata[7:0], seg4_mask);
		end
		// A write to the pin-level register lands in the latch
		if (wr_pend_q && (wr_addr_q == PCM_ADDR_PIN_LEVELS)
			&& (word_addr(haddr) == PCM_ADDR_LATCH))
		begin
			fwd_byte = hwdata[7:0];
		end
	end

	// Read data is captured at the address phase and held for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (rd_take)
		begin
			hrdata <= {24'h00_0000, fwd_byte};
		end
	end

	// Port data registers; writing the pin-level register writes the latch
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			latch_q <= PCM_RST_LATCH;
			dir_q <= PCM_RST_DIRECTION;
		end
		else if (wr_pend_q)
		begin
			case (wr_addr_q)
				PCM_ADDR_PIN_LEVELS: latch_q <= hwdata[7:0];
				PCM_ADDR_LATCH: latch_q <= hwdata[7:0];
				PCM_ADDR_DIRECTION: dir_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Segment enables and open-drain control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			seg1_q <= PCM_RST_SEG;
			seg2_q <= PCM_RST_SEG;
			seg3_q <= PCM_RST_SEG;
			seg4_q <= PCM_RST_SEG;
			od_q <= PCM_RST_OPEN_DRAIN;
		end
		else if (wr_pend_q)
		begin
			case (wr_addr_q)
				PCM_ADDR_SEG_8_15: seg1_q <= hwdata[7:0];
				PCM_ADDR_SEG_16_23: seg2_q <= hwdata[7:0];
				PCM_ADDR_SEG_24_31: seg3_q <= hwdata[7:0];
				// Unimplemented bits are never stored so they cannot leak later
				PCM_ADDR_SEG_32_39: seg4_q <= write_view(wr_addr_q, hwdata[7:0], seg4_mask);
				PCM_ADDR_OPEN_DRAIN: od_q <= write_view(wr_addr_q, hwdata[7:0], seg4_mask);
				default: ;
			endcase
		end
	end

	// Per-pin inputs to the cells: index 0 is pin 6, index 1 is pin 7
	assign cell_seg = {seg3_q[PCM_SEG_EN_28_BIT], seg3_q[PCM_SEG_EN_27_BIT]};
	assign cell_periph_oe = {serial_in.sync_data_oe, serial_in.tx_oe};
	assign cell_periph_out = {serial_in.sync_data_out, serial_in.tx_out};
	assign cell_od = {2{od_q[PCM_OD_SERIAL1_BIT]}};

	// A pin handed to the LCD reads as zero: its digital input is disabled
	assign pin_view = pad_in & ~{cell_seg, 6'h00};

	// Async receive opens only while pin 7 is a digital input; sync receive whenever it is not a segment
	assign rx_async_open = !cell_seg[1] && dir_q[PCM_PIN7];
	assign rx_sync_open = !cell_seg[1];

	// Both upper pins share the same selection structure
	// Index 0 is pin 6, index 1 is pin 7, as in the pad carrier
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			pcm_pin_cell u_cell (
				.seg_en(cell_seg[gi]),
				.dir_in(dir_q[PCM_PIN6 + gi]),
				.latch_bit(latch_q[PCM_PIN6 + gi]),
				.periph_oe(cell_periph_oe[gi]),
				.periph_out(cell_periph_out[gi]),
				.open_drain(cell_od[gi]),
				.pad_out(cell_out[gi]),
				.pad_oe(cell_oe[gi])
			);
		end
	endgenerate

	// Pad drive is registered so every output comes from a flop
	// The flop costs one cycle from a register write to the pad
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pad_q <= '0;
		end
		else
		begin
			pad_q.out <= cell_out;
			pad_q.oe <= cell_oe;
			pad_q.seg_sel <= cell_seg;
		end
	end

	// Receive paths are gated off while pin 7 is a segment; the async one also while it is an output
	// Gating here keeps a segment waveform out of the serial receivers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			async_receive_in <= 1'b1;
			sync_serial_line_in <= 1'b1;
		end
		else
		begin
			// Idle-high when blocked so the receiver sees no false start bit
			async_receive_in <= rx_async_open ? pad_in[PCM_PIN7] : 1'b1;
			// Relies on software leaving the pin as input for sync receive
			sync_serial_line_in <= rx_sync_open ? pad_in[PCM_PIN7] : 1'b1;
		end
	end

	// Open-drain selects exported to the serial and compare units
	// Compare units only take the selects; their pins are muxed elsewhere
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			serial_port_open_drain <= 2'b00;
			compare_unit_open_drain <= 2'b00;
		end
		else
		begin
			serial_port_open_drain <= {od_q[PCM_OD_SERIAL2_BIT], od_q[PCM_OD_SERIAL1_BIT]};
			compare_unit_open_drain <= {od_q[PCM_OD_COMPARE2_BIT], od_q[PCM_OD_COMPARE1_BIT]};
		end
	end

endmodule : pcm_port_mux
`default_nettype wire

// ### testbench/pcm_mux_monitor.sv
// Checker for the upper port pin mux, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module pcm_mux_monitor
	import pcm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] pad_in,
	input wire pcm_serial_s serial_in,
	input wire pcm_pad_s pad_q,
	input wire logic async_receive_in,
	input wire logic sync_serial_line_in,
	input wire logic [1:0] serial_port_open_drain
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Sync data asked for last cycle on a digital pin; a changing od bit is skipped
	sequence s_sync_req;
		$past(hresetn) && $past(serial_in.sync_data_oe) && !pad_q.seg_sel[1]
			&& $stable(serial_port_open_drain);
	endsequence

	chk_segment_drive_28_release: assert property (pad_q.seg_sel[1] |-> !pad_q.oe[1])
		else $error("pin 7 driven while on segment");
	chk_segment_drive_27_release: assert property (pad_q.seg_sel[0] |-> !pad_q.oe[0])
		else $error("pin 6 driven while on segment");
	chk_rx_parked: assert property (pad_q.seg_sel[1] |-> async_receive_in)
		else $error("receiver fed from segment pin");
	chk_sync_line: assert property ($past(hresetn)
		|-> sync_serial_line_in == (pad_q.seg_sel[1] | $past(pad_in[7])))
		else $error("sync line does not follow pin");
	chk_sync_push: assert property (s_sync_req ##0 !serial_port_open_drain[0]
		|-> pad_q.oe[1] && pad_q.out[1] == $past(serial_in.sync_data_out))
		else $error("sync data not on pin 7");
	chk_od_release: assert property (s_sync_req ##0 serial_port_open_drain[0]
		|-> pad_q.oe[1] == !$past(serial_in.sync_data_out))
		else $error("open drain pin 7 wrong");
	chk_tx_drive: assert property ($past(hresetn) && $past(serial_in.tx_oe)
		&& !pad_q.seg_sel[0] && !serial_port_open_drain[0] && $stable(serial_port_open_drain)
		|-> pad_q.oe[0] && pad_q.out[0] == $past(serial_in.tx_out))
		else $error("transmit not on pin 6");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
endmodule : pcm_mux_monitor

bind pcm_port_mux pcm_mux_monitor pcm_mux_monitor_inst (.hclk, .hresetn, .hreadyout,
	.hresp, .pad_in, .serial_in, .pad_q, .async_receive_in, .sync_serial_line_in,
	.serial_port_open_drain);
`default_nettype wire

// ### testbench/pcm_pin_model.sv
// Pin-side model: a driven pad reads its own output, else the outside level
`timescale 1ns/10ps
`default_nettype none
module pcm_pin_model
	import pcm_pkg::*;
(
	input wire pcm_pad_s pad_q,
	input wire logic [7:0] ext_level,
	output logic [7:0] pad_in
);
	// Released or segment pins show the outside level, never a stale drive
	always_comb
	begin
		pad_in = ext_level;
		pad_in[6] = pad_q.oe[0] ? pad_q.out[0] : ext_level[6];
		pad_in[7] = pad_q.oe[1] ? pad_q.out[1] : ext_level[7];
	end
endmodule : pcm_pin_model
`default_nettype wire

// ### testbench/tb_pcm_port_mux.sv
// Testbench for the upper port pin mux over its register bus
`timescale 1ns/10ps
`default_nettype none
module tb_pcm_port_mux;
	import pcm_pkg::*;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [7:0] ext = 8'h00;
	logic [7:0] pad_in;
	pcm_serial_s serial_in = 4'h0;
	pcm_pad_s pad_q;
	logic arx;
	logic ssl;
	logic [1:0] spod;
	logic [1:0] cuod;
	int err_count = 0;
	int comparisons = 0;

	// Small package so the top segment bits are really absent
	pcm_port_mux #(.SMALL_PACKAGE(1'b1)) pcm_port_mux_inst (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .pad_in, .serial_in, .pad_q, .async_receive_in(arx),
		.sync_serial_line_in(ssl), .serial_port_open_drain(spod),
		.compare_unit_open_drain(cuod));
	pcm_pin_model pcm_pin_model_inst (.pad_q, .ext_level(ext), .pad_in);

	// Free running clock
	initial
	begin
		forever #2 hclk = ~hclk;
	end

	task automatic print_verdict;
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for hready; a hang ends the run
	task automatic hwait;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			print_verdict();
		end
	endtask : hwait

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'h1;
		htrans <= PCM_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		r = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'h1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'h0, a, 32'h0, r);
		chk(r, exp);
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge hclk);
	endtask : settle

	// Main sequence
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(PCM_ADDR_LATCH, 32'h0);
		rd(PCM_ADDR_DIRECTION, 32'hff);
		rd(PCM_ADDR_OPEN_DRAIN, 32'h0);
		rd(8'h20, 32'h0);
		wr(PCM_ADDR_LATCH, 32'h80);
		wr(PCM_ADDR_DIRECTION, 32'h7f);
		settle();
		chk(32'(pad_q), 32'h28);
		rd(PCM_ADDR_PIN_LEVELS, 32'h80);
		wr(PCM_ADDR_DIRECTION, 32'hff);
		ext <= 8'h80;
		settle();
		chk(32'(arx), 32'h1);
		ext <= 8'h00;
		settle();
		chk(32'({arx, ssl}), 32'h0);
		// Both serial outputs push with the direction bits at input
		serial_in <= 4'hf;
		settle();
		chk(32'(pad_q), 32'h3c);
		serial_in <= 4'h3;
		wr(PCM_ADDR_OPEN_DRAIN, 32'hff);
		rd(PCM_ADDR_OPEN_DRAIN, 32'he1);
		chk(32'({spod, cuod, pad_q.oe}), 32'h3c);
		serial_in <= 4'h1;
		settle();
		chk(32'(pad_q.oe), 32'h2);
		// Only serial port 1 open drain: tells the two select outputs apart
		wr(PCM_ADDR_OPEN_DRAIN, 32'h80);
		settle();
		chk(32'({spod, cuod, pad_q.oe}), 32'h12);
		// Segments win over the still active sync drive
		wr(PCM_ADDR_SEG_24_31, 32'h18);
		rd(PCM_ADDR_SEG_24_31, 32'h18);
		settle();
		chk(32'({pad_q.oe, pad_q.seg_sel, arx, ssl}), 32'hf);
		// Segment pins read as zero; the other pins still show their levels
		ext <= 8'hc3;
		settle();
		rd(PCM_ADDR_PIN_LEVELS, 32'h03);
		wr(PCM_ADDR_PIN_LEVELS, 32'h40);
		rd(PCM_ADDR_LATCH, 32'h40);
		wr(PCM_ADDR_SEG_32_39, 32'hff);
		rd(PCM_ADDR_SEG_32_39, 32'h1);
		print_verdict();
	end
endmodule : tb_pcm_port_mux
`default_nettype wire
